// ===== src/led_status_regs.vh
// Register map, field positions and timing constants for the port status indicators
`ifndef LED_STATUS_REGS_VH
`define LED_STATUS_REGS_VH

// ***************************************************************
// Register byte offsets
// ***************************************************************
`define REG_CTRL_OFS      4'h0
`define REG_TRAFFIC_OFS   4'h4
`define REG_STATUS_OFS    4'h8

// ***************************************************************
// Control register fields
// ***************************************************************
`define CTRL_SESSION_BIT  0
`define CTRL_POWER_BIT    1
`define CTRL_IDENT_BIT    2
`define CTRL_FATAL_BIT    3
`define CTRL_PROTO_LSB    4
`define CTRL_PROTO_MSB    5
`define CTRL_COMM_BIT     6
`define CTRL_CANST_LSB    8
`define CTRL_CANST_MSB    9
`define CTRL_FRPAS_BIT    10
`define CTRL_WIDTH        11
`define CTRL_RESET        11'h000

// Protocol selection codes
`define PROTO_NONE        2'h0
`define PROTO_CAN         2'h1
`define PROTO_FLEXRAY     2'h2
`define PROTO_LIN         2'h3

// CAN controller error state codes
`define CANST_ACTIVE      2'h0
`define CANST_PASSIVE     2'h1
`define CANST_BUSOFF      2'h2

// Traffic register: writing one here counts as a transmit or receive
`define TRAFFIC_EVT_BIT   0

// ***************************************************************
// Status register fields
// ***************************************************************
`define STAT_LEDS_LSB     0
`define STAT_HOLD_BIT     4
`define STAT_BLINK_BIT    5
`define STAT_ACT_BIT      6
`define STAT_STATE_LSB    8

// ***************************************************************
// Timing
// ***************************************************************
`define CLK_FREQ_HZ       50000000
`define HOLDOFF_MS        1000
`define BLINK_HALF_MS     125
`define ACT_STEP_MS       40
`define HOLDOFF_CYC       ((`CLK_FREQ_HZ / 1000) * `HOLDOFF_MS)
`define BLINK_HALF_CYC    ((`CLK_FREQ_HZ / 1000) * `BLINK_HALF_MS)
`define ACT_STEP_CYC      ((`CLK_FREQ_HZ / 1000) * `ACT_STEP_MS)

// Activity generator seed, any nonzero value
`define ACT_SEED          8'hA5

`endif

// ===== src/rate_tick.v
// Free-running divider giving a one-cycle enable pulse every PERIOD clocks
`default_nettype none

module rate_tick #(
  parameter [31:0] PERIOD = 32'h0000_0010
) (
  input  wire        core_clk,
  input  wire        arst_n,
  output reg         tick
);

  reg [31:0] count_r;

  // ***************************************************************
  // Divider
  // ***************************************************************
  // Count up and wrap; tick is registered to keep the enable glitch free
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_r <= 32'h0000_0000;
      tick    <= 1'b0;
    end else if (count_r >= PERIOD - 32'h0000_0001) begin
      count_r <= 32'h0000_0000;
      tick    <= 1'b1;
    end else begin
      count_r <= count_r + 32'h0000_0001;
      tick    <= 1'b0;
    end
  end

endmodule // rate_tick

`default_nettype wire

// ===== src/activity_pattern.v
// Pseudo-random on/off sequence for the activity display pattern
`include "led_status_regs.vh"
`default_nettype none

module activity_pattern (
  input  wire        core_clk,
  input  wire        arst_n,
  input  wire        step,
  output wire        phase
);

  reg [7:0] lfsr_r;

  // ***************************************************************
  // Maximal length shift register
  // ***************************************************************
  // Taps 8,6,5,4 give a 255 step sequence; never reaches all zeros
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lfsr_r <= `ACT_SEED;
    end else if (step) begin
      lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
    end
  end

  // Lamp state is one bit of the sequence
  assign phase = lfsr_r[0];

endmodule // activity_pattern

`default_nettype wire

// ===== src/port_status_led_driver.v
// Status indicator driver for one bus port: two bicolour lamps behind an Avalon-MM slave
//
// Function
// R1: Each port drives two lamps, each red, green or dark, four patterns.
// R2: First lamp shows hardware in use, second shows bus traffic.
// R3: Blink toggles at fixed rate, solid is fully lit, off is dark.
// R4: Activity pattern switches the lamp following a pseudo-random sequence.
// R5: Identify blinks both lamps green; catastrophic error blinks both red.
// R6: No open session keeps both lamps dark.
// R7: Session, power, no traffic: first lamp solid green, second dark.
// R8: Session without port power: first lamp solid red, second dark.
// R9: CAN error-active traffic: solid green, green activity, dark one second after.
// R10: CAN error-passive traffic: solid green, red activity, same hold-off.
// R11: CAN bus-off: first lamp solid green, second solid red.
// R12: FlexRay normal-active integrated: solid green, green activity throughout.
// R13: FlexRay normal-passive integrated: solid green, red activity throughout.
// R14: LIN communicating: solid green, green activity, dark one second after.
// R15: Identify and catastrophic error override session, power and protocol states.
`include "led_status_regs.vh"
`default_nettype none

module port_status_led_driver #(
  parameter [31:0] HOLDOFF_CYCLES = `HOLDOFF_CYC,
  parameter [31:0] BLINK_CYCLES   = `BLINK_HALF_CYC,
  parameter [31:0] ACT_CYCLES     = `ACT_STEP_CYC
) (
  input  wire        core_clk,
  input  wire        arst_n,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        traffic_pulse,
  output reg         led1_red,
  output reg         led1_green,
  output reg         led2_red,
  output reg         led2_green
);

  // ***************************************************************
  // Display patterns and indication states
  // ***************************************************************
  localparam [1:0] PAT_OFF   = 2'h0;
  localparam [1:0] PAT_SOLID = 2'h1;
  localparam [1:0] PAT_BLINK = 2'h2;
  localparam [1:0] PAT_ACT   = 2'h3;

  localparam [7:0] ST_DARK   = 8'h01;
  localparam [7:0] ST_IDENT  = 8'h02;
  localparam [7:0] ST_FATAL  = 8'h04;
  localparam [7:0] ST_READY  = 8'h08;
  localparam [7:0] ST_NOPWR  = 8'h10;
  localparam [7:0] ST_ACT_G  = 8'h20;
  localparam [7:0] ST_ACT_R  = 8'h40;
  localparam [7:0] ST_BUSOFF = 8'h80;

  // ***************************************************************
  // Functions
  // ***************************************************************
  // Byte address match, ignoring the two lane bits
  function addr_hit;
    input [3:0] addr;
    input [3:0] ofs;
    begin
      addr_hit = (addr[3:2] == ofs[3:2]);
    end
  endfunction

  // Pattern and colour to {red, green} lamp drive
  function [1:0] lamp_drive;
    input [1:0] pat;
    input       red;
    input       blink;
    input       act;
    reg         lit;
    begin
      lit = 1'b0;
      case (pat)
        PAT_OFF:   lit = 1'b0;     // R3
        PAT_SOLID: lit = 1'b1;     // R3
        PAT_BLINK: lit = blink;    // R3
        PAT_ACT:   lit = act;      // R4
        default:   lit = 1'b0;
      endcase
      lamp_drive = red ? {lit, 1'b0} : {1'b0, lit};  // R1
    end
  endfunction

  // ***************************************************************
  // Declarations
  // ***************************************************************
  reg  [`CTRL_WIDTH-1:0] ctrl_r;
  reg                    ack_r;
  reg  [31:0]            hold_cnt_r;
  reg  [7:0]             state_r;
  reg  [7:0]             state_nxt;
  reg                    blink_r;
  reg  [1:0]             pat1;
  reg  [1:0]             pat2;
  reg                    red1;
  reg                    red2;
  wire                   bus_req;
  wire                   wr_done;
  wire                   blink_tick;
  wire                   act_tick;
  wire                   act_phase;
  wire                   soft_traffic;
  wire                   traffic;
  wire                   hold_active;
  wire [1:0]             drive1;
  wire [1:0]             drive2;
  wire [31:0]            status_word;

  // Control fields
  wire                   session_open = ctrl_r[`CTRL_SESSION_BIT];
  wire                   power_good   = ctrl_r[`CTRL_POWER_BIT];
  wire                   ident_req    = ctrl_r[`CTRL_IDENT_BIT];
  wire                   fatal_err    = ctrl_r[`CTRL_FATAL_BIT];
  wire [1:0]             proto        = ctrl_r[`CTRL_PROTO_MSB:`CTRL_PROTO_LSB];
  wire                   comm         = ctrl_r[`CTRL_COMM_BIT];
  wire [1:0]             can_state    = ctrl_r[`CTRL_CANST_MSB:`CTRL_CANST_LSB];
  wire                   fr_passive   = ctrl_r[`CTRL_FRPAS_BIT];

  // ***************************************************************
  // Avalon-MM slave
  // ***************************************************************
  // Every access takes one wait cycle; completes on the edge after ack_r rises
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_r;
  assign wr_done         = avs_write & ack_r;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req & ~ack_r;
    end
  end

  // Control register, byte lanes 0 and 1 only
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= `CTRL_RESET;
    end else if (wr_done && addr_hit(avs_address, `REG_CTRL_OFS)) begin
      if (avs_byteenable[0]) begin
        ctrl_r[7:0] <= avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        ctrl_r[`CTRL_WIDTH-1:8] <= avs_writedata[`CTRL_WIDTH-1:8];
      end
    end
  end

  // Traffic strobe from software, lane 0
  assign soft_traffic = wr_done & addr_hit(avs_address, `REG_TRAFFIC_OFS) &
                        avs_byteenable[0] & avs_writedata[`TRAFFIC_EVT_BIT];

  // Status word shows lamps, timers and indication state
  assign status_word = {16'h0000, state_r, 1'b0, act_phase, blink_r, hold_active,
                        led1_red, led1_green, led2_red, led2_green};

  // Read data captured in the wait cycle, stands at the completing edge
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_r) begin
      if (addr_hit(avs_address, `REG_CTRL_OFS)) begin
        avs_readdata <= {21'h00_0000, ctrl_r};
      end else if (addr_hit(avs_address, `REG_STATUS_OFS)) begin
        avs_readdata <= status_word;
      end else begin
        avs_readdata <= 32'h0000_0000;  // Unmapped and write-only read zero
      end
    end
  end

  // ***************************************************************
  // Pattern sources
  // ***************************************************************
  rate_tick #(
    .PERIOD (BLINK_CYCLES)
  ) u_blink_tick (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .tick     (blink_tick)
  );

  rate_tick #(
    .PERIOD (ACT_CYCLES)
  ) u_act_tick (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .tick     (act_tick)
  );

  // Pseudo-random on/off sequence, stepped at the fixed ACT_CYCLES rate
  activity_pattern u_act (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .step     (act_tick),
    .phase    (act_phase)
  );

  // Blink phase shared by both lamps so they flash together
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      blink_r <= 1'b0;
    end else if (blink_tick) begin
      blink_r <= ~blink_r;  // R3
    end
  end

  // ***************************************************************
  // Traffic hold-off
  // ***************************************************************
  // Any transmit or receive restarts the one second window
  assign traffic     = traffic_pulse | soft_traffic;
  assign hold_active = (hold_cnt_r != 32'h0000_0000);

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hold_cnt_r <= 32'h0000_0000;
    end else if (traffic) begin
      hold_cnt_r <= HOLDOFF_CYCLES;  // R9 R14
    end else if (hold_active) begin
      hold_cnt_r <= hold_cnt_r - 32'h0000_0001;
    end
  end

  // ***************************************************************
  // Indication state selection
  // ***************************************************************
  // Fixed priority; protocol states only once session and power are fine
  always @* begin
    state_nxt = ST_READY;
    if (fatal_err) begin
      state_nxt = ST_FATAL;  // R5 R15
    end else if (ident_req) begin
      state_nxt = ST_IDENT;  // R5 R15
    end else if (!session_open) begin
      state_nxt = ST_DARK;   // R6
    end else if (!power_good) begin
      state_nxt = ST_NOPWR;  // R8
    end else begin
      case (proto)
        `PROTO_CAN: begin
          if (can_state == `CANST_BUSOFF) begin
            state_nxt = ST_BUSOFF;  // R11
          end else if (comm && hold_active) begin
            state_nxt = (can_state == `CANST_PASSIVE) ? ST_ACT_R : ST_ACT_G;  // R9 R10
          end else begin
            state_nxt = ST_READY;  // R7
          end
        end
        `PROTO_FLEXRAY: begin
          // Integration alone keeps activity going; no hold-off here
          if (comm) begin
            state_nxt = fr_passive ? ST_ACT_R : ST_ACT_G;  // R12 R13
          end else begin
            state_nxt = ST_READY;  // R7
          end
        end
        `PROTO_LIN: begin
          if (comm && hold_active) begin
            state_nxt = ST_ACT_G;  // R14
          end else begin
            state_nxt = ST_READY;  // R7
          end
        end
        default: begin
          state_nxt = ST_READY;  // R7
        end
      endcase
    end
  end

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= ST_DARK;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ***************************************************************
  // Lamp patterns per state
  // ***************************************************************
  // First lamp tracks use, second tracks bus traffic
  always @* begin
    pat1 = PAT_OFF;
    pat2 = PAT_OFF;
    red1 = 1'b0;
    red2 = 1'b0;
    case (state_r)
      ST_DARK: begin
        pat1 = PAT_OFF;    // R6
        pat2 = PAT_OFF;
      end
      ST_IDENT: begin
        pat1 = PAT_BLINK;  // R5
        pat2 = PAT_BLINK;
      end
      ST_FATAL: begin
        pat1 = PAT_BLINK;  // R5
        pat2 = PAT_BLINK;
        red1 = 1'b1;
        red2 = 1'b1;
      end
      ST_READY: begin
        pat1 = PAT_SOLID;  // R7
        pat2 = PAT_OFF;
      end
      ST_NOPWR: begin
        pat1 = PAT_SOLID;  // R8
        red1 = 1'b1;
        pat2 = PAT_OFF;
      end
      ST_ACT_G: begin
        pat1 = PAT_SOLID;  // R2
        pat2 = PAT_ACT;    // R9 R12 R14
      end
      ST_ACT_R: begin
        pat1 = PAT_SOLID;  // R2
        pat2 = PAT_ACT;    // R10 R13
        red2 = 1'b1;
      end
      ST_BUSOFF: begin
        pat1 = PAT_SOLID;  // R11
        pat2 = PAT_SOLID;
        red2 = 1'b1;
      end
      default: begin
        pat1 = PAT_OFF;
        pat2 = PAT_OFF;
      end
    endcase
  end

  assign drive1 = lamp_drive(pat1, red1, blink_r, act_phase);
  assign drive2 = lamp_drive(pat2, red2, blink_r, act_phase);

  // ***************************************************************
  // Lamp outputs
  // ***************************************************************
  // Registered so the pins never glitch between colours
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      led1_red   <= 1'b0;
      led1_green <= 1'b0;
      led2_red   <= 1'b0;
      led2_green <= 1'b0;
    end else begin
      led1_red   <= drive1[1];  // R1
      led1_green <= drive1[0];
      led2_red   <= drive2[1];
      led2_green <= drive2[0];
    end
  end

endmodule // port_status_led_driver

`default_nettype wire

// ===== bench/port_status_led_driver_asserts.sv
// Concurrent checks on the lamp driver ports, bound into the driver
`default_nettype none

module lamp_checker #(
  parameter [31:0] HOLDOFF_CYCLES = 32'h0000_0032
) (
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic [3:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  input wire logic        traffic_pulse,
  input wire logic        led1_red,
  input wire logic        led1_green,
  input wire logic        led2_red,
  input wire logic        led2_green
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // Margin of two cycles beyond the lamp path, so a slow but legal drop never fires
  localparam int HOLD_END = HOLDOFF_CYCLES + 4;
  logic [10:0] ctrl_s;
  logic [1:0]  st_cnt;
  int          idle;
  wire logic       wr_ok = avs_write && !avs_waitrequest;
  wire logic       evt   = traffic_pulse || (wr_ok && avs_address[3:2] == 2'h1
                           && avs_byteenable[0] && avs_writedata[0]);
  wire logic       ok    = st_cnt >= 2'h2 && !ctrl_s[2] && !ctrl_s[3];
  wire logic       up    = ok && ctrl_s[0] && ctrl_s[1];
  wire logic [1:0] pro   = ctrl_s[5:4];
  wire logic [3:0] lamps = {led1_red, led1_green, led2_red, led2_green};

  // Shadow of the control word and cycles since the last traffic event
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_s <= 11'h000;
      st_cnt <= 2'h0;
      idle   <= HOLD_END;
    end else begin
      idle <= evt ? 0 : (idle < HOLD_END ? idle + 1 : idle);
      if (wr_ok && avs_address[3:2] == 2'h0) begin
        if (avs_byteenable[0]) ctrl_s[7:0] <= avs_writedata[7:0];
        if (avs_byteenable[1]) ctrl_s[10:8] <= avs_writedata[10:8];
        st_cnt <= 2'h0;
      end else if (st_cnt != 2'h3) begin
        st_cnt <= st_cnt + 2'h1;
      end
    end
  end

  property p_no_mix; !(led1_red && led1_green) && !(led2_red && led2_green); endproperty
  a_no_mix: assert property (p_no_mix)
    else $error("lamp lit red and green together");
  property p_dark; ok && !ctrl_s[0] |-> lamps == 4'h0; endproperty
  a_dark: assert property (p_dark)
    else $error("lamps lit without a session");
  property p_ready; up && pro == 2'h0 |-> lamps == 4'h4; endproperty
  a_ready: assert property (p_ready)
    else $error("ready state not solid green and dark");
  property p_nopwr; ok && ctrl_s[0] && !ctrl_s[1] |-> lamps == 4'h8; endproperty
  a_nopwr: assert property (p_nopwr)
    else $error("missing power not solid red and dark");
  property p_ident;
    st_cnt >= 2'h2 && ctrl_s[2] && !ctrl_s[3] |-> !led1_red && !led2_red
      && led1_green == led2_green;
  endproperty
  a_ident: assert property (p_ident)
    else $error("identify not green on both lamps together");
  property p_fatal;
    st_cnt >= 2'h2 && ctrl_s[3] |-> !led1_green && !led2_green && led1_red == led2_red;
  endproperty
  a_fatal: assert property (p_fatal)
    else $error("fatal error not red on both lamps");
  property p_blink;
    // A fresh control write ends the blink legally, so it also closes the window
    st_cnt >= 2'h2 && (ctrl_s[2] || ctrl_s[3])
      |-> ##[1:8] ($changed(led1_green || led1_red) || st_cnt == 2'h0);
  endproperty
  a_blink: assert property (p_blink)
    else $error("blink lamp stuck");
  property p_busoff; up && pro == 2'h1 && ctrl_s[9:8] == 2'h2 |-> lamps == 4'h6; endproperty
  a_busoff: assert property (p_busoff)
    else $error("bus-off not green and solid red");
  property p_can_act;
    up && pro == 2'h1 && ctrl_s[9:8] == 2'h0 |-> led1_green && !led2_red;
  endproperty
  a_can_act: assert property (p_can_act)
    else $error("error-active shows red");
  property p_holdoff;
    up && (pro == 2'h3 || (pro == 2'h1 && ctrl_s[9:8] != 2'h2)) && idle >= HOLD_END
      |-> !led2_red && !led2_green;
  endproperty
  a_holdoff: assert property (p_holdoff)
    else $error("traffic lamp lit after hold-off");
  property p_fr_act;
    up && pro == 2'h2 && ctrl_s[6] && !ctrl_s[10]
      |-> ##[1:40] ($changed(led2_green) || st_cnt == 2'h0);
  endproperty
  a_fr_act: assert property (p_fr_act)
    else $error("integrated activity stopped");
  property p_fr_pas;
    up && pro == 2'h2 && ctrl_s[6] && ctrl_s[10] |-> led1_green && !led2_green;
  endproperty
  a_fr_pas: assert property (p_fr_pas)
    else $error("normal-passive shows green traffic");
  property p_wait; $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait)
    else $error("bus answer not after one wait cycle");

  c_ident: cover property (st_cnt == 2'h3 && ctrl_s[2]);
  c_busoff: cover property (up && pro == 2'h1 && ctrl_s[9:8] == 2'h2);
  c_expire: cover property (up && idle == HOLD_END - 1);
endmodule // lamp_checker

bind port_status_led_driver lamp_checker #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES)) i_chk (
  .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .traffic_pulse(traffic_pulse), .led1_red(led1_red), .led1_green(led1_green),
  .led2_red(led2_red), .led2_green(led2_green));
`default_nettype wire

// ===== bench/lamp_observer.sv
// Operator model: counts how often each lamp colour lights up
`default_nettype none

module lamp_observer (
  input wire logic         core_clk,
  input wire logic         arst_n,
  input wire logic [3:0]   lamps,
  output var logic [15:0]  rises [0:3]
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] prev;

  // Rising edges per colour: index 3 led1 red, 2 led1 green, 1 led2 red, 0 led2 green
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev <= 4'h0;
      for (int i = 0; i < 4; i++) rises[i] <= 16'h0000;
    end else begin
      prev <= lamps;
      for (int i = 0; i < 4; i++) if (lamps[i] && !prev[i]) rises[i] <= rises[i] + 16'h0001;
    end
  end
endmodule // lamp_observer
`default_nettype wire

// ===== bench/port_status_led_driver_bench.sv
// Self-checking bench for the port status lamp driver
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end

module port_status_led_driver_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HOLD = 50;
  logic        core_clk, arst_n, avs_read, avs_write, traffic_pulse;
  logic        avs_waitrequest, led1_red, led1_green, led2_red, led2_green;
  logic [3:0]  avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [15:0] rises [0:3];
  logic [15:0] snap [0:3];
  logic [15:0] dlt [0:3];
  int          fail_count = 0;
  int          n_checks = 0;
  wire logic [3:0] lamps = {led1_red, led1_green, led2_red, led2_green};
  // Steady states: control word, then lamps {l1 red, l1 green, l2 red, l2 green}
  localparam logic [14:0] ROWS [0:9] = '{{11'h000, 4'h0}, {11'h002, 4'h0},
    {11'h003, 4'h4}, {11'h001, 4'h8}, {11'h213, 4'h6}, {11'h253, 4'h6},
    {11'h013, 4'h4}, {11'h053, 4'h4}, {11'h023, 4'h4}, {11'h073, 4'h4}};
  // Blink cases: control word, colour index on lamp one
  localparam logic [12:0] BLINKS [0:2] = '{{11'h007, 2'h2}, {11'h00F, 2'h3}, {11'h008, 2'h3}};
  // Activity cases: control word, event source (0 pin, 1 bus, 2 none), colour index
  localparam logic [14:0] ACTS [0:4] = '{{11'h053, 2'h0, 2'h0}, {11'h153, 2'h1, 2'h1},
    {11'h073, 2'h0, 2'h0}, {11'h063, 2'h2, 2'h0}, {11'h463, 2'h2, 2'h1}};

  port_status_led_driver #(.HOLDOFF_CYCLES(HOLD), .BLINK_CYCLES(4), .ACT_CYCLES(3)) i_dut (
    .core_clk(core_clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .traffic_pulse(traffic_pulse), .led1_red(led1_red), .led1_green(led1_green),
    .led2_red(led2_red), .led2_green(led2_green));
  lamp_observer i_lamps (.core_clk(core_clk), .arst_n(arst_n), .lamps(lamps), .rises(rises));

  // One bus transfer; request held until waitrequest is seen low at an edge
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // No local limit: only the watchdog ends a wait that never answers
    do begin
      @(posedge core_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Colour rises over a span of n cycles
  task automatic watch(input int n);
    snap = rises;
    repeat (n) @(posedge core_clk);
    for (int i = 0; i < 4; i++) dlt[i] = rises[i] - snap[i];
  endtask

  // Traffic from the pin or from the register
  task automatic traffic(input logic [1:0] k);
    if (k == 2'h1) begin
      xfer(1'b1, 4'h4, 32'h0000_0001);
    end else begin
      @(posedge core_clk);
      traffic_pulse <= 1'b1;
      @(posedge core_clk);
      traffic_pulse <= 1'b0;
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Clock at 50 MHz
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Cut a hang short, well past the expected run of about eleven hundred cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    int c;
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    traffic_pulse = 1'b0;
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    `CHK(lamps, 4'h0)
    xfer(1'b0, 4'h0, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    // Read-only status, write-only traffic and a hole in the map
    xfer(1'b1, 4'h8, 32'hFFFF_FFFF);
    xfer(1'b1, 4'hC, 32'hFFFF_FFFF);
    xfer(1'b0, 4'h8, 32'h0000_0000);
    `CHK({rd[15:8], rd[3:0]}, 12'h010)
    xfer(1'b0, 4'h4, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    xfer(1'b0, 4'hC, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    $display("reset and map test done");
    for (int r = 0; r < 10; r++) begin
      xfer(1'b1, 4'h0, {21'h00_0000, ROWS[r][14:4]});
      repeat (4) @(posedge core_clk);
      `CHK(lamps, ROWS[r][3:0])
      xfer(1'b0, 4'h8, 32'h0000_0000);
      `CHK(rd[3:0], ROWS[r][3:0])
      xfer(1'b0, 4'h0, 32'h0000_0000);
      `CHK(rd[10:0], ROWS[r][14:4])
    end
    $display("steady state table done");
    for (int b = 0; b < 3; b++) begin
      c = BLINKS[b][1:0];
      xfer(1'b1, 4'h0, {21'h00_0000, BLINKS[b][12:2]});
      repeat (4) @(posedge core_clk);
      watch(40);
      `CHK(dlt[c] >= 4 && dlt[c] <= 5, 1'b1)
      `CHK(dlt[c - 2], dlt[c])
      `CHK(dlt[c ^ 1] + dlt[(c ^ 1) - 2], 16'h0000)
    end
    $display("blink test done");
    for (int a = 0; a < 5; a++) begin
      c = ACTS[a][1:0];
      xfer(1'b1, 4'h0, {21'h00_0000, ACTS[a][14:4]});
      // Let the lamps of the previous case settle before counting
      repeat (4) @(posedge core_clk);
      if (ACTS[a][3:2] != 2'h2) traffic(ACTS[a][3:2]);
      watch(ACTS[a][3:2] == 2'h2 ? 150 : 45);
      `CHK(dlt[c] > 0, 1'b1)
      `CHK(dlt[c ^ 1] + dlt[3], 16'h0000)
      `CHK(led1_green, 1'b1)
      if (ACTS[a][3:2] != 2'h2) begin
        // A second event must restart the hold-off, not let the first one expire
        traffic(ACTS[a][3:2]);
        repeat (30) @(posedge core_clk);
        xfer(1'b0, 4'h8, 32'h0000_0000);
        `CHK(rd[4], 1'b1)
        repeat (HOLD + 10) @(posedge core_clk);
        `CHK(lamps, 4'h4)
        xfer(1'b0, 4'h8, 32'h0000_0000);
        `CHK(rd[4], 1'b0)
      end
    end
    $display("activity test done");
    // Reset in mid-run drops the control word and darkens both lamps
    xfer(1'b1, 4'h0, 32'h0000_0007);
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK(lamps, 4'h0)
    arst_n <= 1'b1;
    xfer(1'b0, 4'h0, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000)
    $display("mid-run reset test done");
    wrap_up();
  end
endmodule // port_status_led_driver_bench
`default_nettype wire
